// ### iosp_map.svh
// register offsets, reset values and timing counts for the peripheral register space
`ifndef IOSP_MAP_SVH
`define IOSP_MAP_SVH
`define IOSP_DATA_OFFSET     6'h20
`define IOSP_BIT_LIMIT       6'h1F
`define IOSP_ADC_RES_LO      6'h04
`define IOSP_ADC_RES_HI      6'h05
`define IOSP_ADC_CSR         6'h06
`define IOSP_ADC_CHAN        6'h07
`define IOSP_CMP_CSR         6'h08
`define IOSP_SER_BAUD        6'h09
`define IOSP_SER_CTRL        6'h0A
`define IOSP_SER_STAT        6'h0B
`define IOSP_SER_DATA        6'h0C
`define IOSP_SPI_CTRL        6'h0D
`define IOSP_SPI_STAT        6'h0E
`define IOSP_SPI_DATA        6'h0F
`define IOSP_PD_PIN          6'h10
`define IOSP_PD_DIR          6'h11
`define IOSP_PD_OUT          6'h12
`define IOSP_PC_PIN          6'h13
`define IOSP_PC_DIR          6'h14
`define IOSP_PC_OUT          6'h15
`define IOSP_PB_PIN          6'h16
`define IOSP_PB_DIR          6'h17
`define IOSP_PB_OUT          6'h18
`define IOSP_PA_PIN          6'h19
`define IOSP_PA_DIR          6'h1A
`define IOSP_PA_OUT          6'h1B
`define IOSP_NV_CTRL         6'h1C
`define IOSP_NV_BYTE         6'h1D
`define IOSP_NV_ADDR_LO      6'h1E
`define IOSP_NV_ADDR_HI      6'h1F
`define IOSP_WDT_CTRL        6'h21
`define IOSP_ASYNC_STAT      6'h22
`define IOSP_T2_CMP          6'h23
`define IOSP_T2_CNT          6'h24
`define IOSP_T2_CTRL         6'h25
`define IOSP_T1_CAP_LO       6'h26
`define IOSP_T1_CAP_HI       6'h27
`define IOSP_T1_CMPB_LO      6'h28
`define IOSP_T1_CMPB_HI      6'h29
`define IOSP_T1_CMPA_LO      6'h2A
`define IOSP_T1_CMPA_HI      6'h2B
`define IOSP_T1_CNT_LO       6'h2C
`define IOSP_T1_CNT_HI       6'h2D
`define IOSP_T1_CTRL_B       6'h2E
`define IOSP_T1_CTRL_A       6'h2F
`define IOSP_T0_CNT          6'h32
`define IOSP_T0_CTRL         6'h33
`define IOSP_CORE_RST_STAT   6'h34
`define IOSP_CORE_CTRL       6'h35
`define IOSP_TMR_FLAGS       6'h38
`define IOSP_REG_RESET       8'h00
`define IOSP_PC_RESET        12'h000
`define IOSP_SRAM_CYCLES     2'h2
`define IOSP_NV_DEPTH        512
`define IOSP_NV_BYTE_RESET   8'hFF
`endif

// ### iosp_pkg.sv
// types shared by the peripheral register space block
`default_nettype none
package iosp_pkg;
  // cpu-side operation kinds
  typedef enum logic [3:0] {
    IOSP_OP_NONE    = 4'b0000,
    IOSP_OP_PIN     = 4'b0001,
    IOSP_OP_POUT    = 4'b0010,
    IOSP_OP_LD      = 4'b0011,
    IOSP_OP_ST      = 4'b0100,
    IOSP_OP_BSET    = 4'b0101,
    IOSP_OP_BCLR    = 4'b0110,
    IOSP_OP_SKSET   = 4'b0111,
    IOSP_OP_SKCLR   = 4'b1000,
    IOSP_OP_CONST   = 4'b1001,
    IOSP_OP_PJMP    = 4'b1010,
    IOSP_OP_OJMP    = 4'b1011
  } iosp_op_t;
  // one request from the core
  typedef struct packed {
    iosp_op_t    op;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [2:0]  bit_sel;
    logic [11:0] offset;
  } iosp_req_t;
  // answer back to the core
  typedef struct packed {
    logic        valid;
    logic [7:0]  rdata;
    logic        skip;
  } iosp_rsp_t;
  // data sram access sequencer
  typedef enum logic [1:0] {
    IOSP_SR_IDLE = 2'b00,
    IOSP_SR_WAIT = 2'b01
  } iosp_sram_t;
endpackage
`default_nettype wire

// ### iosp_top.sv
// peripheral register space, program addressing and nonvolatile byte store
// How it works
// - z bit 0 picks byte, bits 12..1 pick word
// - pointer jump loads counter from z
// - offset jump adds signed offset plus one
// - separate byte-addressed nonvolatile store
// - core runs straight off system clock
// - fetch overlaps execute, one per cycle
// - register operation completes in one cycle
// - data sram access takes two cycles
// - port ops move one byte to registers
// - port addresses span 0x00 to 0x3F
// - data-space view adds 0x20 to address
// - bit ops only below 0x20
// - flags clear on written one only
// - bit set/clear rewrites whole register
// - each listed address decodes its register
`include "iosp_map.svh"
`default_nettype none
module iosp_top
  import iosp_pkg::*;
(
  input  wire logic        i_sys_clk,    // system clock, undivided
  input  wire logic        i_rst,        // synchronous reset
  input  wire iosp_req_t   i_req,        // core request
  input  wire logic [15:0] i_z_ptr,      // z pointer value
  input  wire logic [15:0] i_prog_word,  // program word at o_prog_addr
  input  wire logic [7:0]  i_flag_set,   // hardware timer flag events
  input  wire logic [31:0] i_port_pins,  // pins a..d, a in low byte
  input  wire logic [7:0]  i_periph_ro,  // value shown on read-only peripherals
  output logic      [11:0] o_prog_addr,  // program word address
  output logic      [11:0] o_program_counter, // current program counter
  output logic      [31:0] o_port_out,   // port output latches a..d
  output logic      [31:0] o_port_oe,    // port directions a..d
  output logic             o_sram_busy,  // data sram access in progress
  output iosp_rsp_t        o_rsp         // answer to core
);

  logic [7:0]  rw_ff [0:63];        // writable peripheral storage
  logic [7:0]  tmr_flags_ff;        // write-one-to-clear timer flags
  logic [7:0]  nvmem [0:`IOSP_NV_DEPTH-1]; // nonvolatile byte store
  logic [11:0] pc_ff;               // program counter
  iosp_rsp_t   rsp_ff;              // registered answer
  iosp_sram_t  sram_st_ff;          // sram access state
  logic [5:0]  ioa;                 // decoded port address
  logic        in_io;               // request targets port space
  logic        is_rd;               // read-type request
  logic        is_wr;               // whole-byte write request
  logic        is_bitop;            // bit set or clear
  logic        is_skip;             // bit test
  logic        bit_ok;              // bit op in reach
  logic        mapped;              // address is listed
  logic        writable;            // address has writable storage
  logic [7:0]  rd_val;              // current register value
  logic [7:0]  wr_val;              // value going back in
  logic [8:0]  nv_addr;             // nonvolatile byte address
  logic        nv_wr;               // nonvolatile write strobe
  logic        nv_rd;               // nonvolatile fetch strobe
  logic [11:0] nxt_pc;              // next program counter

  // decode port view and data-space view
  always_comb
  begin
    in_io = 1'b0;
    ioa   = i_req.addr[5:0];
    unique case (i_req.op)
      IOSP_OP_PIN, IOSP_OP_POUT, IOSP_OP_BSET, IOSP_OP_BCLR, IOSP_OP_SKSET, IOSP_OP_SKCLR:
      begin
        in_io = (i_req.addr[15:6] == 10'h000);
      end
      IOSP_OP_LD, IOSP_OP_ST:
      begin
        // data view sits 0x20 above port view
        ioa   = 6'(i_req.addr - 16'(`IOSP_DATA_OFFSET));
        in_io = (i_req.addr >= 16'(`IOSP_DATA_OFFSET))
              && (i_req.addr < 16'(`IOSP_DATA_OFFSET) + 16'h0040);
      end
      default:
      begin
        in_io = 1'b0;
      end
    endcase
  end

  assign is_rd    = in_io && (i_req.op == IOSP_OP_PIN || i_req.op == IOSP_OP_LD);
  assign is_wr    = in_io && (i_req.op == IOSP_OP_POUT || i_req.op == IOSP_OP_ST);
  assign bit_ok   = (ioa <= `IOSP_BIT_LIMIT);
  assign is_bitop = in_io && bit_ok && (i_req.op == IOSP_OP_BSET || i_req.op == IOSP_OP_BCLR);
  assign is_skip  = in_io && bit_ok && (i_req.op == IOSP_OP_SKSET || i_req.op == IOSP_OP_SKCLR);

  // address decode of listed registers
  always_comb
  begin
    mapped   = 1'b1;
    writable = 1'b1;
    rd_val   = 8'h00;
    unique case (ioa)
      `IOSP_ADC_RES_LO, `IOSP_ADC_RES_HI, `IOSP_SPI_STAT, `IOSP_T1_CAP_LO, `IOSP_T1_CAP_HI:
      begin
        writable = 1'b0;
        rd_val   = i_periph_ro;
      end
      `IOSP_PD_PIN: begin writable = 1'b0; rd_val = i_port_pins[31:24]; end
      `IOSP_PC_PIN: begin writable = 1'b0; rd_val = i_port_pins[23:16]; end
      `IOSP_PB_PIN: begin writable = 1'b0; rd_val = i_port_pins[15:8];  end
      `IOSP_PA_PIN: begin writable = 1'b0; rd_val = i_port_pins[7:0];   end
      `IOSP_TMR_FLAGS: rd_val = tmr_flags_ff;
      `IOSP_ADC_CSR, `IOSP_ADC_CHAN, `IOSP_CMP_CSR, `IOSP_SER_BAUD, `IOSP_SER_CTRL,
      `IOSP_SER_STAT, `IOSP_SER_DATA, `IOSP_SPI_CTRL, `IOSP_SPI_DATA,
      `IOSP_PD_DIR, `IOSP_PD_OUT, `IOSP_PC_DIR, `IOSP_PC_OUT, `IOSP_PB_DIR, `IOSP_PB_OUT,
      `IOSP_PA_DIR, `IOSP_PA_OUT, `IOSP_NV_CTRL, `IOSP_NV_BYTE, `IOSP_NV_ADDR_LO,
      `IOSP_NV_ADDR_HI, `IOSP_WDT_CTRL, `IOSP_ASYNC_STAT, `IOSP_T2_CMP, `IOSP_T2_CNT,
      `IOSP_T2_CTRL, `IOSP_T1_CMPB_LO, `IOSP_T1_CMPB_HI, `IOSP_T1_CMPA_LO, `IOSP_T1_CMPA_HI,
      `IOSP_T1_CNT_LO, `IOSP_T1_CNT_HI, `IOSP_T1_CTRL_B, `IOSP_T1_CTRL_A, `IOSP_T0_CNT,
      `IOSP_T0_CTRL, `IOSP_CORE_RST_STAT, `IOSP_CORE_CTRL:
        rd_val = rw_ff[ioa];
      default:
      begin
        // reserved: read zero, no storage
        mapped   = 1'b0;
        writable = 1'b0;
        rd_val   = 8'h00;
      end
    endcase
  end

  // value written back, bit ops rewrite whole byte
  always_comb
  begin
    wr_val = i_req.wdata;
    if (i_req.op == IOSP_OP_BSET)
    begin
      wr_val = rd_val | (8'h01 << i_req.bit_sel);
    end
    else if (i_req.op == IOSP_OP_BCLR)
    begin
      wr_val = rd_val & ~(8'h01 << i_req.bit_sel);
    end
  end

  // plain writable peripheral storage
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < 64; i++)
      begin
        rw_ff[i] <= `IOSP_REG_RESET;
      end
    end
    else if ((is_wr || is_bitop) && mapped && writable && ioa != `IOSP_TMR_FLAGS)
    begin
      rw_ff[ioa] <= wr_val;
      // fetch strobe pulls the addressed stored byte into the data register
      if (nv_rd)
      begin
        rw_ff[`IOSP_NV_BYTE] <= nvmem[nv_addr];
      end
    end
  end

  // timer flags: hardware set wins over software clear
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      tmr_flags_ff <= `IOSP_REG_RESET;
    end
    else if ((is_wr || is_bitop) && ioa == `IOSP_TMR_FLAGS)
    begin
      tmr_flags_ff <= (tmr_flags_ff & ~wr_val) | i_flag_set;
    end
    else
    begin
      tmr_flags_ff <= tmr_flags_ff | i_flag_set;
    end
  end

  // nonvolatile store: byte address from its address registers
  assign nv_addr = {rw_ff[`IOSP_NV_ADDR_HI][0], rw_ff[`IOSP_NV_ADDR_LO]};
  assign nv_wr   = (is_wr || is_bitop) && ioa == `IOSP_NV_CTRL && wr_val[1];
  // control bit 0 fetches a byte back; reads the old byte if both bits are set
  assign nv_rd   = (is_wr || is_bitop) && ioa == `IOSP_NV_CTRL && wr_val[0];

  // separate byte space, one byte written per strobe
  always_ff @(posedge i_sys_clk)
  begin
    if (nv_wr)
    begin
      nvmem[nv_addr] <= rw_ff[`IOSP_NV_BYTE];
    end
  end

  // data sram access: two cycles, busy in the second
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      sram_st_ff <= IOSP_SR_IDLE;
    end
    else
    begin
      unique case (sram_st_ff)
        IOSP_SR_IDLE:
        begin
          if ((i_req.op == IOSP_OP_LD || i_req.op == IOSP_OP_ST) && !in_io)
          begin
            sram_st_ff <= IOSP_SR_WAIT;
          end
        end
        IOSP_SR_WAIT:
        begin
          sram_st_ff <= IOSP_SR_IDLE;
        end
        default:
        begin
          sram_st_ff <= IOSP_SR_IDLE;
        end
      endcase
    end
  end
  assign o_sram_busy = (sram_st_ff == IOSP_SR_WAIT);

  // program counter: pointer jump, offset jump, else step
  always_comb
  begin
    nxt_pc = pc_ff + 12'h001;
    if (i_req.op == IOSP_OP_PJMP)
    begin
      nxt_pc = i_z_ptr[11:0];
    end
    else if (i_req.op == IOSP_OP_OJMP)
    begin
      // 12-bit signed offset covers -2048..2047, wraps in space
      nxt_pc = pc_ff + i_req.offset + 12'h001;
    end
  end

  // counter advances every undivided system clock
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      pc_ff <= `IOSP_PC_RESET;
    end
    else
    begin
      pc_ff <= nxt_pc;
    end
  end

  // program fetch address: constant load uses z word part
  assign o_prog_addr = (i_req.op == IOSP_OP_CONST) ? i_z_ptr[12:1] : pc_ff;
  assign o_program_counter = pc_ff;

  // answer register, one cycle after request
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      rsp_ff <= '0;
    end
    else
    begin
      rsp_ff.valid <= (i_req.op != IOSP_OP_NONE);
      rsp_ff.skip  <= is_skip && (rd_val[i_req.bit_sel] == (i_req.op == IOSP_OP_SKSET));
      if (i_req.op == IOSP_OP_CONST)
      begin
        rsp_ff.rdata <= i_z_ptr[0] ? i_prog_word[15:8] : i_prog_word[7:0];
      end
      else if (is_rd)
      begin
        rsp_ff.rdata <= rd_val;
      end
      else
      begin
        rsp_ff.rdata <= 8'h00;
      end
    end
  end
  assign o_rsp = rsp_ff;

  // port latches and directions, a in low byte
  assign o_port_out = {rw_ff[`IOSP_PD_OUT], rw_ff[`IOSP_PC_OUT],
                       rw_ff[`IOSP_PB_OUT], rw_ff[`IOSP_PA_OUT]};
  assign o_port_oe  = {rw_ff[`IOSP_PD_DIR], rw_ff[`IOSP_PC_DIR],
                       rw_ff[`IOSP_PB_DIR], rw_ff[`IOSP_PA_DIR]};

endmodule // iosp_top
`default_nettype wire

// ### iosp_props.sv
// concurrent checks on the ports of the register space block
`default_nettype none
module iosp_props
  import iosp_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire iosp_req_t   i_req,
  input wire logic [15:0] i_z_ptr,
  input wire logic [15:0] i_prog_word,
  input wire logic [11:0] o_prog_addr,
  input wire logic [11:0] o_program_counter,
  input wire logic [31:0] o_port_out,
  input wire logic [31:0] o_port_oe,
  input wire logic        o_sram_busy,
  input wire iosp_rsp_t   o_rsp
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic sram_op; // data access beyond the port view
  logic bit_op;  // bit set, clear or skip request
  assign sram_op = (i_req.op == IOSP_OP_LD || i_req.op == IOSP_OP_ST) && i_req.addr > 16'h005F;
  assign bit_op = i_req.op inside {IOSP_OP_BSET, IOSP_OP_BCLR, IOSP_OP_SKSET, IOSP_OP_SKCLR};
  property p_ans; i_req.op != IOSP_OP_NONE |=> o_rsp.valid; endproperty
  a_ans: assert property (p_ans) else $error("request not answered");
  property p_pc_step;
    !(i_req.op inside {IOSP_OP_PJMP, IOSP_OP_OJMP}) |=> o_program_counter == $past(o_program_counter) + 12'h001;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("counter did not step");
  property p_pjmp; i_req.op == IOSP_OP_PJMP |=> o_program_counter == $past(i_z_ptr[11:0]); endproperty
  a_pjmp: assert property (p_pjmp) else $error("pointer jump target wrong");
  property p_ojmp;
    i_req.op == IOSP_OP_OJMP |=> o_program_counter == $past(o_program_counter) + $past(i_req.offset) + 12'h001;
  endproperty
  a_ojmp: assert property (p_ojmp) else $error("offset jump target wrong");
  property p_cadr; i_req.op == IOSP_OP_CONST |-> o_prog_addr == i_z_ptr[12:1]; endproperty
  a_cadr: assert property (p_cadr) else $error("constant word address wrong");
  property p_cbyte;
    i_req.op == IOSP_OP_CONST |=> o_rsp.rdata == ($past(i_z_ptr[0]) ? $past(i_prog_word[15:8]) : $past(i_prog_word[7:0]));
  endproperty
  a_cbyte: assert property (p_cbyte) else $error("constant byte wrong");
  property p_sram; sram_op ##1 !sram_op |-> o_sram_busy ##1 !o_sram_busy; endproperty
  a_sram: assert property (p_sram) else $error("sram access not two cycles");
  property p_bit_hi; bit_op && i_req.addr > 16'h001F |=> !o_rsp.skip && $stable(o_port_out); endproperty
  a_bit_hi: assert property (p_bit_hi) else $error("bit op above limit acted");
  property p_pout_b; i_req.op == IOSP_OP_POUT && i_req.addr == 16'h0018 |=> o_port_out[15:8] == $past(i_req.wdata); endproperty
  a_pout_b: assert property (p_pout_b) else $error("port write lost");
  property p_st_b; i_req.op == IOSP_OP_ST && i_req.addr == 16'h0038 |=> o_port_out[15:8] == $past(i_req.wdata); endproperty
  a_st_b: assert property (p_st_b) else $error("data view write lost");
  property p_pout_hi; i_req.op == IOSP_OP_POUT && i_req.addr > 16'h003F |=> $stable(o_port_oe); endproperty
  a_pout_hi: assert property (p_pout_hi) else $error("port write beyond range acted");
endmodule // iosp_props
`default_nettype wire

// ### iosp_prog_model.sv
// program memory model answering the word address at once
`default_nettype none
module iosp_prog_model
(
  input  wire logic [11:0] i_addr, // word address from the block
  output logic      [15:0] o_word  // word held there
);
  // index in the high byte, its inverse below, so the halves differ
  assign o_word = {i_addr[7:0], ~i_addr[7:0]};
endmodule // iosp_prog_model
`default_nettype wire

// ### io_space_and_program_addressing_tb.sv
// self-checking bench for the register space block
`default_nettype none
module io_space_and_program_addressing_tb
  import iosp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] PINS = 32'h4433_2211; // pin levels a..d
  localparam logic [7:0]  RO   = 8'h6C;         // read-only peripheral value
  logic        sys_clk;   // system clock
  logic        rst;       // reset
  iosp_req_t   req;       // core request
  logic [15:0] z_ptr;     // z pointer
  logic [15:0] prog_word; // program word
  logic [7:0]  flag_set;  // flag events
  logic [11:0] prog_addr; // word address
  logic [11:0] pc;        // program counter
  logic [11:0] pc0;       // counter when a request is taken
  logic [31:0] port_out;  // output latches
  logic [31:0] port_oe;   // directions
  logic        sram_busy; // sram access
  iosp_rsp_t   rsp;       // answer
  int          miscompares;
  int          n_tests;
  int          cycles;
  iosp_top uut (.i_sys_clk(sys_clk), .i_rst(rst), .i_req(req), .i_z_ptr(z_ptr),
    .i_prog_word(prog_word), .i_flag_set(flag_set), .i_port_pins(PINS), .i_periph_ro(RO),
    .o_prog_addr(prog_addr), .o_program_counter(pc), .o_port_out(port_out),
    .o_port_oe(port_oe), .o_sram_busy(sram_busy), .o_rsp(rsp));
  iosp_prog_model u_mem (.i_addr(prog_addr), .o_word(prog_word));
  // clock at 50 ns
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // hang guard
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask
  // one request, answer stands on return
  task automatic op(input iosp_op_t k, input logic [15:0] a, input logic [7:0] d,
                    input logic [2:0] b, input logic [11:0] f);
    @(negedge sys_clk);
    req = '{k, a, d, b, f};
    pc0 = pc;
    @(negedge sys_clk);
    req.op = IOSP_OP_NONE;
  endtask
  // read value expected after the write pass
  function automatic logic [7:0] exp_rd(input int a);
    case (a)
      4, 5, 14, 38, 39: return RO;
      16, 19, 22, 25: return PINS[8 * (3 - (a - 16) / 3) +: 8];
      0, 1, 2, 3, 32, 48, 49, 54, 55, 56: return 8'h00;
      default: return 8'(a) ^ 8'hA5;
    endcase
  endfunction
  // main sequence
  initial
  begin
    rst = 1'b1;
    req = '0;
    z_ptr = 16'h0000;
    flag_set = 8'h00;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    check(port_out, 32'h0000_0000);
    for (int a = 0; a < 57; a++)
    begin
      // software never writes reserved addresses, it only reads them
      if (!(a inside {0, 1, 2, 3, 32, 48, 49, 54, 55}))
      begin
        op(IOSP_OP_POUT, 16'(a), 8'(a) ^ 8'hA5, 3'h0, 12'h000);
      end
      op(IOSP_OP_LD, 16'(a + 32), 8'h00, 3'h0, 12'h000);
      check(rsp.rdata, exp_rd(a));
    end
    check(port_out, 32'hB7B0_BDBE);
    check(port_oe, 32'hB4B1_B2BF);
    // port write beyond 0x3F must not alias onto a direction register
    op(IOSP_OP_POUT, 16'h0057, 8'h00, 3'h0, 12'h000);
    check(port_oe, 32'hB4B1_B2BF);
    op(IOSP_OP_BSET, 16'h0018, 8'h00, 3'h1, 12'h000);
    check(port_out[15:8], 8'hBF);
    op(IOSP_OP_BCLR, 16'h0018, 8'h00, 3'h7, 12'h000);
    check(port_out[15:8], 8'h3F);
    op(IOSP_OP_SKSET, 16'h0018, 8'h00, 3'h0, 12'h000);
    check(rsp.skip, 1'b1);
    op(IOSP_OP_SKCLR, 16'h0018, 8'h00, 3'h6, 12'h000);
    check(rsp.skip, 1'b1);
    op(IOSP_OP_SKCLR, 16'h0018, 8'h00, 3'h0, 12'h000);
    check(rsp.skip, 1'b0);
    op(IOSP_OP_BSET, 16'h0021, 8'h00, 3'h0, 12'h000);
    op(IOSP_OP_LD, 16'h0041, 8'h00, 3'h0, 12'h000);
    check(rsp.rdata, 8'h84);
    op(IOSP_OP_ST, 16'h0038, 8'h66, 3'h0, 12'h000);
    check(port_out[15:8], 8'h66);
    // nonvolatile byte: store at address 3, clobber the data register, fetch back
    op(IOSP_OP_POUT, 16'h001D, 8'h5A, 3'h0, 12'h000);
    op(IOSP_OP_POUT, 16'h001E, 8'h03, 3'h0, 12'h000);
    op(IOSP_OP_POUT, 16'h001C, 8'h02, 3'h0, 12'h000);
    op(IOSP_OP_POUT, 16'h001D, 8'h00, 3'h0, 12'h000);
    op(IOSP_OP_POUT, 16'h001C, 8'h01, 3'h0, 12'h000);
    op(IOSP_OP_PIN, 16'h001D, 8'h00, 3'h0, 12'h000);
    check(rsp.rdata, 8'h5A);
    @(negedge sys_clk);
    flag_set = 8'h05;
    @(negedge sys_clk);
    flag_set = 8'h00;
    op(IOSP_OP_PIN, 16'h0038, 8'h00, 3'h0, 12'h000);
    check(rsp.rdata, 8'h05);
    op(IOSP_OP_POUT, 16'h0038, 8'h01, 3'h0, 12'h000);
    op(IOSP_OP_BSET, 16'h0038, 8'h00, 3'h2, 12'h000);
    op(IOSP_OP_PIN, 16'h0038, 8'h00, 3'h0, 12'h000);
    check(rsp.rdata, 8'h04);
    for (int i = 0; i < 4; i++)
    begin
      z_ptr = (i < 2) ? 16'(6 + i) : 16'(16'h1FFC + i);
      op(IOSP_OP_CONST, 16'h0000, 8'h00, 3'h0, 12'h000);
      check(rsp.rdata, z_ptr[0] ? z_ptr[8:1] : 8'(~z_ptr[8:1]));
    end
    z_ptr = 16'h0ABC;
    op(IOSP_OP_PJMP, 16'h0000, 8'h00, 3'h0, 12'h000);
    check(pc, 12'hABC);
    for (int i = 0; i < 3; i++)
    begin
      op(IOSP_OP_OJMP, 16'h0000, 8'h00, 3'h0, 12'h7FF + 12'(i));
      check(pc, 12'(pc0 + 12'h7FF + 12'(i) + 12'h001));
    end
    op(IOSP_OP_LD, 16'h0100, 8'h00, 3'h0, 12'h000);
    check(sram_busy, 1'b1);
    @(negedge sys_clk);
    check(sram_busy, 1'b0);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    check(pc, 12'h000);
    check(port_out, 32'h0000_0000);
    rst = 1'b0;
    complete_run();
  end
endmodule // io_space_and_program_addressing_tb
bind iosp_top iosp_props u_props (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_req(i_req),
  .i_z_ptr(i_z_ptr), .i_prog_word(i_prog_word), .o_prog_addr(o_prog_addr),
  .o_program_counter(o_program_counter), .o_port_out(o_port_out), .o_port_oe(o_port_oe),
  .o_sram_busy(o_sram_busy), .o_rsp(o_rsp));
`default_nettype wire
